// [design/ldcr_pkg.sv]
// Package for the LED dimming configuration register bank.
// Assumes a 16-bit register port with byte offsets as printed.
package ldcr_pkg;
  localparam logic [7:0] BRIGHT_OFS = 8'h00;
  localparam logic [7:0] CURR_OFS = 8'h02;
  localparam logic [7:0] RAMP_OFS = 8'h04;
  localparam logic [7:0] FAULT_OFS = 8'h06;
  localparam logic [15:0] BRIGHT_RST = 16'h0000;
  localparam logic [15:0] CURR_RST = 16'h0FFF;
  localparam logic [15:0] RAMP_RST = 16'h08A3;
  localparam logic [15:0] FAULT_RST = 16'h0100;
  localparam int CURR_LSB = 0;
  localparam int SS_EN_BIT = 14;
  localparam int SS_RATE_LSB = 12;
  localparam int SS_SPAN_LSB = 10;
  localparam int SRC_LSB = 8;
  localparam int RAMP_LSB = 5;
  localparam int DITHER_LSB = 2;
  localparam int SMOOTH_BIT = 1;
  localparam int GND_DET_BIT = 8;
  localparam int MASK_LSB = 0;
  localparam logic [1:0] SRC_PWM = 2'h0;
  localparam logic [1:0] SRC_REG = 2'h2;
endpackage

// [design/ldcr_regs.sv]
// Configuration register bank of a four-channel LED driver.
// Assumes a simple synchronous register port from the host interface logic.
`timescale 1ns/1ps
module ldcr_regs (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] pwm_level_i,
  output logic [15:0] rdata_o,
  output logic [11:0] analog_current_level_o,
  output logic spread_enable_o,
  output logic [1:0] spread_modulation_rate_o,
  output logic [1:0] boost_oscillator_span_o,
  output logic [1:0] brightness_source_select_o,
  output logic [2:0] ramp_time_select_o,
  output logic [2:0] dither_select_o,
  output logic smooth_ramp_enable_o,
  output logic ground_short_detect_enable_o,
  output logic [3:0] string_short_mask_o,
  output logic [15:0] brightness_word_o
);
  logic [15:0] bright_ff, curr_ff, ramp_ff, fault_ff, rdata_ff, bright_out_ff;
  logic [15:0] nxt_bright, nxt_curr, nxt_ramp, nxt_fault, nxt_rdata, nxt_bright_out;

  always_comb begin
    nxt_bright = bright_ff;
    nxt_curr = curr_ff;
    nxt_ramp = ramp_ff;
    nxt_fault = fault_ff;
    nxt_rdata = rdata_ff;
    if (wr_en_i) begin
      case (addr_i)
        ldcr_pkg::BRIGHT_OFS: nxt_bright = wdata_i;
        ldcr_pkg::CURR_OFS: nxt_curr = wdata_i;
        ldcr_pkg::RAMP_OFS: nxt_ramp = wdata_i;
        ldcr_pkg::FAULT_OFS: nxt_fault = wdata_i;
        default: nxt_curr = curr_ff;
      endcase
    end
    if (rd_en_i) begin
      case (addr_i)
        ldcr_pkg::BRIGHT_OFS: nxt_rdata = bright_ff;
        ldcr_pkg::CURR_OFS: nxt_rdata = curr_ff;
        ldcr_pkg::RAMP_OFS: nxt_rdata = ramp_ff;
        ldcr_pkg::FAULT_OFS: nxt_rdata = fault_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
    // Reserved codes fall back to the pin so the sloper never sees an undefined source
    if (ramp_ff[ldcr_pkg::SRC_LSB +: 2] == ldcr_pkg::SRC_REG) begin
      nxt_bright_out = bright_ff;
    end else begin
      nxt_bright_out = pwm_level_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bright_ff <= ldcr_pkg::BRIGHT_RST;
      curr_ff <= ldcr_pkg::CURR_RST;
      ramp_ff <= ldcr_pkg::RAMP_RST;
      fault_ff <= ldcr_pkg::FAULT_RST;
      rdata_ff <= 16'h0000;
      bright_out_ff <= 16'h0000;
    end else begin
      bright_ff <= nxt_bright;
      curr_ff <= nxt_curr;
      ramp_ff <= nxt_ramp;
      fault_ff <= nxt_fault;
      rdata_ff <= nxt_rdata;
      bright_out_ff <= nxt_bright_out;
    end
  end

  // Smoothing lengthens ramps in the sloper downstream; this bank only exports the style bit
  assign rdata_o = rdata_ff;
  assign analog_current_level_o = curr_ff[ldcr_pkg::CURR_LSB +: 12];
  assign spread_enable_o = ramp_ff[ldcr_pkg::SS_EN_BIT];
  assign spread_modulation_rate_o = ramp_ff[ldcr_pkg::SS_RATE_LSB +: 2];
  assign boost_oscillator_span_o = ramp_ff[ldcr_pkg::SS_SPAN_LSB +: 2];
  assign brightness_source_select_o = ramp_ff[ldcr_pkg::SRC_LSB +: 2];
  assign ramp_time_select_o = ramp_ff[ldcr_pkg::RAMP_LSB +: 3];
  assign dither_select_o = ramp_ff[ldcr_pkg::DITHER_LSB +: 3];
  assign smooth_ramp_enable_o = ramp_ff[ldcr_pkg::SMOOTH_BIT];
  assign ground_short_detect_enable_o = fault_ff[ldcr_pkg::GND_DET_BIT];
  assign string_short_mask_o = fault_ff[ldcr_pkg::MASK_LSB +: 4];
  assign brightness_word_o = bright_out_ff;

  property p_curr_write;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::CURR_OFS |=> analog_current_level_o == $past(wdata_i[11:0]);
  endproperty
  a_curr_write: assert property (p_curr_write) else $error("current level not written");

  property p_ss_en;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::RAMP_OFS |=> spread_enable_o == $past(wdata_i[14]);
  endproperty
  a_ss_en: assert property (p_ss_en) else $error("spread enable wrong");

  property p_rate;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::RAMP_OFS |=> spread_modulation_rate_o == $past(wdata_i[13:12]);
  endproperty
  a_rate: assert property (p_rate) else $error("spread rate wrong");

  property p_span;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::RAMP_OFS |=> boost_oscillator_span_o == $past(wdata_i[11:10]);
  endproperty
  a_span: assert property (p_span) else $error("spread span wrong");

  property p_src_reg;
    @(posedge ref_clk_i) disable iff (reset_i)
      brightness_source_select_o == ldcr_pkg::SRC_REG && $stable(brightness_source_select_o) && !wr_en_i
      |=> brightness_word_o == $past(bright_ff);
  endproperty
  a_src_reg: assert property (p_src_reg) else $error("register brightness not routed");

  property p_src_pin;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && brightness_source_select_o == ldcr_pkg::SRC_PWM |=> brightness_word_o == $past(pwm_level_i);
  endproperty
  a_src_pin: assert property (p_src_pin) else $error("pin brightness not routed");

  property p_ramp;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::RAMP_OFS |=> ramp_time_select_o == $past(wdata_i[7:5])
      && dither_select_o == $past(wdata_i[4:2]);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp or dither wrong");

  property p_smooth;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::RAMP_OFS |=> smooth_ramp_enable_o == $past(wdata_i[1]);
  endproperty
  a_smooth: assert property (p_smooth) else $error("smooth bit wrong");

  property p_fault;
    @(posedge ref_clk_i) disable iff (reset_i)
      wr_en_i && addr_i == ldcr_pkg::FAULT_OFS |=> string_short_mask_o == $past(wdata_i[3:0])
      && ground_short_detect_enable_o == $past(wdata_i[8]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault config wrong");

  property p_readback;
    @(posedge ref_clk_i) disable iff (reset_i)
      !wr_en_i ##1 rd_en_i && !wr_en_i && addr_i == ldcr_pkg::RAMP_OFS |=> rdata_o == $past(ramp_ff);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  // Reset sampled high means the next edge still shows reset values
  property p_rst_curr;
    @(posedge ref_clk_i)
      reset_i |=> analog_current_level_o == ldcr_pkg::CURR_RST[ldcr_pkg::CURR_LSB +: 12];
  endproperty
  a_rst_curr: assert property (p_rst_curr) else $error("current level reset value wrong");

  property p_rst_ss_en;
    @(posedge ref_clk_i)
      reset_i |=> spread_enable_o == ldcr_pkg::RAMP_RST[ldcr_pkg::SS_EN_BIT];
  endproperty
  a_rst_ss_en: assert property (p_rst_ss_en) else $error("spread enable reset value wrong");

  property p_rst_rate;
    @(posedge ref_clk_i)
      reset_i |=> spread_modulation_rate_o == ldcr_pkg::RAMP_RST[ldcr_pkg::SS_RATE_LSB +: 2];
  endproperty
  a_rst_rate: assert property (p_rst_rate) else $error("spread rate reset value wrong");

  property p_rst_span;
    @(posedge ref_clk_i)
      reset_i |=> boost_oscillator_span_o == ldcr_pkg::RAMP_RST[ldcr_pkg::SS_SPAN_LSB +: 2];
  endproperty
  a_rst_span: assert property (p_rst_span) else $error("spread span reset value wrong");

  property p_rst_src;
    @(posedge ref_clk_i)
      reset_i |=> brightness_source_select_o == ldcr_pkg::RAMP_RST[ldcr_pkg::SRC_LSB +: 2];
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("source select reset value wrong");

  property p_rst_ramp;
    @(posedge ref_clk_i)
      reset_i |=> ramp_time_select_o == ldcr_pkg::RAMP_RST[ldcr_pkg::RAMP_LSB +: 3];
  endproperty
  a_rst_ramp: assert property (p_rst_ramp) else $error("ramp time reset value wrong");

  property p_rst_dither;
    @(posedge ref_clk_i)
      reset_i |=> dither_select_o == ldcr_pkg::RAMP_RST[ldcr_pkg::DITHER_LSB +: 3];
  endproperty
  a_rst_dither: assert property (p_rst_dither) else $error("dither reset value wrong");

  property p_rst_smooth;
    @(posedge ref_clk_i)
      reset_i |=> smooth_ramp_enable_o == ldcr_pkg::RAMP_RST[ldcr_pkg::SMOOTH_BIT];
  endproperty
  a_rst_smooth: assert property (p_rst_smooth) else $error("smooth bit reset value wrong");

  property p_rst_word;
    @(posedge ref_clk_i)
      reset_i |=> ramp_ff == ldcr_pkg::RAMP_RST;
  endproperty
  a_rst_word: assert property (p_rst_word) else $error("ramp word reset value wrong");

  property p_rst_gnd;
    @(posedge ref_clk_i)
      reset_i |=> ground_short_detect_enable_o == ldcr_pkg::FAULT_RST[ldcr_pkg::GND_DET_BIT];
  endproperty
  a_rst_gnd: assert property (p_rst_gnd) else $error("ground detect reset value wrong");

  property p_rst_mask;
    @(posedge ref_clk_i)
      reset_i |=> string_short_mask_o == ldcr_pkg::FAULT_RST[ldcr_pkg::MASK_LSB +: 4];
  endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("short mask reset value wrong");

  property p_rst_bright;
    @(posedge ref_clk_i)
      reset_i |=> bright_ff == ldcr_pkg::BRIGHT_RST;
  endproperty
  a_rst_bright: assert property (p_rst_bright) else $error("brightness reset value wrong");

  property p_curr_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      !(wr_en_i && addr_i == ldcr_pkg::CURR_OFS)
      |=> $stable(curr_ff);
  endproperty
  a_curr_hold: assert property (p_curr_hold) else $error("current word changed without a write");

  property p_ramp_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      !(wr_en_i && addr_i == ldcr_pkg::RAMP_OFS)
      |=> $stable(ramp_ff);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp word changed without a write");

  property p_fault_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      !(wr_en_i && addr_i == ldcr_pkg::FAULT_OFS)
      |=> $stable(fault_ff);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault word changed without a write");

  property p_bright_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      !(wr_en_i && addr_i == ldcr_pkg::BRIGHT_OFS)
      |=> $stable(bright_ff);
  endproperty
  a_bright_hold: assert property (p_bright_hold) else $error("brightness changed without a write");

  property p_rd_curr;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && rd_en_i && addr_i == ldcr_pkg::CURR_OFS
      |=> rdata_o == $past(curr_ff);
  endproperty
  a_rd_curr: assert property (p_rd_curr) else $error("current word readback wrong");

  property p_rd_fault;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && rd_en_i && addr_i == ldcr_pkg::FAULT_OFS
      |=> rdata_o == $past(fault_ff);
  endproperty
  a_rd_fault: assert property (p_rd_fault) else $error("fault word readback wrong");

  property p_rd_bright;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && rd_en_i && addr_i == ldcr_pkg::BRIGHT_OFS
      |=> rdata_o == $past(bright_ff);
  endproperty
  a_rd_bright: assert property (p_rd_bright) else $error("brightness readback wrong");

  property p_ramp_word;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && wr_en_i && addr_i == ldcr_pkg::RAMP_OFS
      |=> ramp_ff == $past(wdata_i);
  endproperty
  a_ramp_word: assert property (p_ramp_word) else $error("ramp word not stored whole");

  property p_dither;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && wr_en_i && addr_i == ldcr_pkg::RAMP_OFS
      |=> dither_select_o == $past(wdata_i[ldcr_pkg::DITHER_LSB +: 3]);
  endproperty
  a_dither: assert property (p_dither) else $error("dither select wrong");

  property p_gnd_det;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && wr_en_i && addr_i == ldcr_pkg::FAULT_OFS
      |=> ground_short_detect_enable_o == $past(wdata_i[ldcr_pkg::GND_DET_BIT]);
  endproperty
  a_gnd_det: assert property (p_gnd_det) else $error("ground detect enable wrong");

  property p_src_other;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i && brightness_source_select_o != ldcr_pkg::SRC_REG
      |=> brightness_word_o == $past(pwm_level_i);
  endproperty
  a_src_other: assert property (p_src_other) else $error("non register source not routed to pin");
endmodule

// [tb/led_dimming_config_regs_tb_top.sv]
// Self-checking bench for the LED dimming configuration register bank.
// Assumes the bank's register strobes are one-cycle pulses on a single clock.
`timescale 1ns/1ps
module led_dimming_config_regs_tb_top;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, pwm_level_i = 16'h0000, rdata_o, brightness_word_o;
  logic [11:0] analog_current_level_o;
  logic spread_enable_o, smooth_ramp_enable_o, ground_short_detect_enable_o;
  logic [1:0] spread_modulation_rate_o, boost_oscillator_span_o, brightness_source_select_o;
  logic [2:0] ramp_time_select_o, dither_select_o;
  logic [3:0] string_short_mask_o;
  logic [15:0] m [4];
  logic [7:0] a;
  logic [15:0] d;
  integer seed = 32'h2D1D08B6, mismatches = 0, compares = 0, i;
  always #2.5 ref_clk_i = ~ref_clk_i;
  ldcr_regs u_dut (.ref_clk_i, .reset_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .pwm_level_i, .rdata_o,
    .analog_current_level_o, .spread_enable_o, .spread_modulation_rate_o, .boost_oscillator_span_o,
    .brightness_source_select_o, .ramp_time_select_o, .dither_select_o, .smooth_ramp_enable_o,
    .ground_short_detect_enable_o, .string_short_mask_o, .brightness_word_o);
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (e !== s) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task mreset();
    m[0] = ldcr_pkg::BRIGHT_RST;
    m[1] = ldcr_pkg::CURR_RST;
    m[2] = ldcr_pkg::RAMP_RST;
    m[3] = ldcr_pkg::FAULT_RST;
  endtask
  // Pwm level changes only with a write, so the lagged brightness is steady at check time
  task wr(input logic [7:0] ad, input logic [15:0] dt);
    @(posedge ref_clk_i);
    wr_en_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= dt;
    pwm_level_i <= 16'($random(seed));
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    if (ad < 8'h08) m[ad[2:1]] = dt;
  endtask
  task rd(input logic [7:0] ad);
    @(posedge ref_clk_i);
    rd_en_i <= 1'b1;
    addr_i <= ad;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk("rdata", (ad < 8'h08) ? m[ad[2:1]] : 16'h0000, rdata_o);
  endtask
  task outs();
    @(posedge ref_clk_i);
    #1;
    chk("current", m[1][11:0], analog_current_level_o);
    chk("spread_en", m[2][14], spread_enable_o);
    chk("rate", m[2][13:12], spread_modulation_rate_o);
    chk("span", m[2][11:10], boost_oscillator_span_o);
    chk("source", m[2][9:8], brightness_source_select_o);
    chk("ramp", m[2][7:5], ramp_time_select_o);
    chk("dither", m[2][4:2], dither_select_o);
    chk("smooth", m[2][1], smooth_ramp_enable_o);
    chk("gnd_det", m[3][8], ground_short_detect_enable_o);
    chk("mask", m[3][3:0], string_short_mask_o);
    chk("bright", (m[2][9:8] == 2'h2) ? m[0] : pwm_level_i, brightness_word_o);
  endtask
  task finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
  initial begin
    mreset();
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    outs();
    for (i = 0; i < 5; i++) rd(8'(2 * i));
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      // Software may only use the pin and register codes
      wr(ldcr_pkg::RAMP_OFS, {m[2][15:10], 2'(i & 2), m[2][7:0]});
      outs();
    end
    $display("test source codes done");
    for (i = 0; i < 300; i++) begin
      a = 8'($unsigned($random(seed)) % 8) << 1;
      d = 16'($random(seed));
      if (a == ldcr_pkg::RAMP_OFS && (d[7:5] == 3'h1 || d[7:5] == 3'h2)) d[1] = 1'b0;
      if (a == ldcr_pkg::RAMP_OFS) d[ldcr_pkg::SRC_LSB] = 1'b0;
      wr(a, d);
      outs();
      rd(8'($unsigned($random(seed)) % 8) << 1);
    end
    $display("test random traffic done");
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    mreset();
    outs();
    for (i = 0; i < 4; i++) rd(8'(2 * i));
    $display("test second reset done");
    finish_test();
  end
endmodule
